// >>> src/adcsq_pkg.sv
// Constants, field layout and types shared by the converter sequence control block.
package adcsq_pkg;

  // ****************************************************************
  // Register map: word indices, byte address is four times the index.
  // ****************************************************************
  localparam logic [7:0] CTRL_INDEX = 8'h3b;
  localparam logic [7:0] SEL_INDEX = 8'h3c;
  localparam logic [7:0] STATUS_INDEX = 8'h3f;
  localparam int ADDR_W = 12;

  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] SEL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WRITE_MASK = 16'hff03;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int RATE_LSB = 14;
  localparam int SEQ_LSB = 12;
  localparam int DIAG_EN_LSB = 8;
  localparam int MAIN_EN_LSB = 0;
  localparam int SEL_FIELD_W = 4;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_POWERED_BIT = 1;
  localparam int ST_WAKING_BIT = 2;
  localparam int ST_SLOT_LSB = 4;
  localparam int ST_COUNT_LSB = 8;

  localparam int MAIN_SLOTS = 2;
  localparam int DIAG_SLOTS = 4;
  localparam int SLOTS = MAIN_SLOTS + DIAG_SLOTS;

  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int CLK_MHZ = 250;
  localparam int POWER_UP_US = 100;
  localparam int POWER_UP_CYCLES = POWER_UP_US * CLK_MHZ;

  // ****************************************************************
  // Codes and types.
  // ****************************************************************
  typedef enum logic [1:0] {
    SEQ_STANDBY = 2'h0,
    SEQ_SINGLE = 2'h1,
    SEQ_CONTINUOUS = 2'h2,
    SEQ_POWER_DOWN = 2'h3
  } adcsq_seq_t;

  typedef enum logic [1:0] {
    RATE_20SPS = 2'h0,
    RATE_4K8SPS = 2'h1,
    RATE_9K6SPS = 2'h2
  } adcsq_rate_t;

  typedef enum logic [4:0] {
    NODE_ANALOG_GROUND,
    NODE_TEMPERATURE,
    NODE_DIGITAL_SUPPLY,
    NODE_ANALOG_SUPPLY,
    NODE_ANALOG_REGULATOR_1V8,
    NODE_DIGITAL_REGULATOR_1V8,
    NODE_REFERENCE_OUTPUT,
    NODE_POSITIVE_SUPPLY,
    NODE_NEGATIVE_SUPPLY,
    NODE_LOW_VOLTAGE_INPUT,
    NODE_SENSE_LOW,
    NODE_EXTERNAL_SENSE_ONE,
    NODE_EXTERNAL_SENSE_TWO,
    NODE_OUTPUT_SUPPLY,
    NODE_SINK_CURRENT,
    NODE_SOURCE_CURRENT
  } adcsq_node_t;

endpackage : adcsq_pkg

// >>> src/adcsq_seq_if.sv
// Interface between the register side and the slot sequencer.
interface adcsq_seq_if;
  logic [1:0] seq_code;
  logic start_req;
  logic [5:0] slot_en;
  logic wake_done;
  logic conv_done;
  logic powered;
  logic waking;
  logic busy;
  logic [2:0] slot;
  logic conv_start;
  logic seq_end;

  modport ctrl (
    output seq_code, start_req, slot_en, wake_done, conv_done,
    input powered, waking, busy, slot, conv_start, seq_end
  );
  modport seq (
    input seq_code, start_req, slot_en, wake_done, conv_done,
    output powered, waking, busy, slot, conv_start, seq_end
  );
endinterface : adcsq_seq_if

// >>> src/adcsq_sequencer.sv
// Slot sequencer: walks the enabled slots and handles standby and power-down.
module adcsq_sequencer
  import adcsq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  adcsq_seq_if.seq sq
);

  typedef enum logic [2:0] {
    ST_DOWN, ST_WAKE, ST_STANDBY, ST_SELECT, ST_ISSUE, ST_WAIT
  } adcsq_state_t;

  adcsq_state_t state_q;
  logic [2:0] slot_q;
  logic [2:0] scan_q;
  logic pend_q;
  logic [3:0] nxt;

  // Lowest enabled slot at or above the scan position, with a found flag on top.
  function automatic logic [3:0] adcsq_next(input logic [5:0] en, input logic [2:0] from);
    logic [3:0] r;
    r = 4'h0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (en[i] && (3'(i) >= from)) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction : adcsq_next

  assign nxt = adcsq_next(sq.slot_en, scan_q);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_STANDBY;
      slot_q <= 3'h0;
      scan_q <= 3'h0;
    end else begin
      case (state_q)
        ST_DOWN: begin
          if (sq.start_req || sq.seq_code == SEQ_STANDBY) begin
            state_q <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (sq.wake_done) begin
            // A start that lands in the last wake cycle must not be lost.
            state_q <= (pend_q || sq.start_req) ? ST_SELECT : ST_STANDBY;
            scan_q <= 3'h0;
          end
        end
        ST_STANDBY: begin
          if (sq.start_req) begin
            state_q <= ST_SELECT;
            scan_q <= 3'h0;
          end else if (sq.seq_code == SEQ_POWER_DOWN) begin
            state_q <= ST_DOWN;
          end
        end
        ST_SELECT: begin
          if (nxt[3]) begin
            slot_q <= nxt[2:0];
            scan_q <= 3'(nxt[2:0] + 3'h1);
            state_q <= ST_ISSUE;
          end else if (sq.seq_code == SEQ_CONTINUOUS) begin
            scan_q <= 3'h0;
          end else if (sq.seq_code == SEQ_POWER_DOWN) begin
            state_q <= ST_DOWN;
          end else begin
            state_q <= ST_STANDBY;
          end
        end
        ST_ISSUE: begin
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (sq.conv_done) begin
            state_q <= ST_SELECT;
          end
        end
        default: begin
          state_q <= ST_STANDBY;
        end
      endcase
    end
  end

  // A start seen while asleep is remembered until the converter is awake.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_q <= 1'b0;
    end else if (state_q == ST_WAKE && sq.wake_done) begin
      pend_q <= 1'b0;
    end else if (sq.start_req && (state_q == ST_DOWN || state_q == ST_WAKE)) begin
      pend_q <= 1'b1;
    end
  end

  assign sq.powered = (state_q != ST_DOWN) && (state_q != ST_WAKE);
  assign sq.waking = (state_q == ST_WAKE);
  assign sq.busy = (state_q == ST_SELECT) || (state_q == ST_ISSUE) ||
                   (state_q == ST_WAIT) || (state_q == ST_WAKE && pend_q);
  assign sq.slot = slot_q;
  assign sq.conv_start = (state_q == ST_ISSUE);
  assign sq.seq_end = (state_q == ST_SELECT) && !nxt[3];

endmodule : adcsq_sequencer

// >>> src/adcsq_top.sv
// Converter sequence control: APB registers, slot routing and power-up timing.
//
// How it works
// - Diagnostic rate code 00 is 20 SPS, 01 is 4.8 kSPS, 10 is 9.6 kSPS.
// - Any other diagnostic rate code falls back to 20 SPS.
// - Sequence code 00 is standby; a running loop ends its sequence, stays powered.
// - Sequence code 01 converts each enabled slot once, then goes idle.
// - Sequence code 10 loops; when stopped it completes the current sequence first.
// - Sequence code 11 powers down; waking up takes 100 us before converting.
// - Four diagnostic slot enables, slot 3 at bit 11; only enabled slots run.
// - Main slot enables sit in bits 1 and 0; bits 7 to 2 read zero.
// - Selector register holds four 4-bit fields, slot 3 high, slot 0 low.
// - Selector codes 0000 to 0110 pick ground, sensors and supplies; 1110 is ground.
// - Selector codes 0111 to 1101 pick supplies, inputs, sense nodes, output supply.
// - Slot 0 code 1111 measures the output stage sinking current.
// - In a higher slot, code 1111 measures the output stage sourcing current.
module adcsq_top
  import adcsq_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = POWER_UP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic conv_done,
  output logic adc_power_on,
  output logic conv_start,
  output logic [2:0] conv_slot,
  output logic conv_is_diag,
  output logic [1:0] diag_rate,
  output logic [4:0] diag_node,
  output logic [3:0] diag_code,
  output logic adc_busy
);

  localparam int WAKE_W = $clog2(WAKE_CYCLES + 1);
  localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_CYCLES - 1);

  // ****************************************************************
  // Storage.
  // ****************************************************************
  logic [15:0] ctrl_q;
  logic [15:0] sel_q;
  logic [7:0] seq_count_q;
  logic start_req_q;
  logic [WAKE_W-1:0] wake_cnt_q;
  logic wake_done_q;

  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;

  logic conv_start_q;
  logic [2:0] conv_slot_q;
  logic conv_is_diag_q;
  logic [1:0] diag_rate_q;
  logic [4:0] diag_node_q;
  logic [3:0] diag_code_q;
  logic adc_power_on_q;
  logic adc_busy_q;

  adcsq_seq_if sq ();

  // ****************************************************************
  // APB decode.
  // ****************************************************************
  logic access;
  logic [7:0] word_index;
  logic aligned;
  logic hit_ctrl;
  logic hit_sel;
  logic hit_status;
  logic mapped;
  logic wr_take;
  logic [15:0] lane_mask;
  logic [15:0] status_word;
  logic [15:0] read_word;

  assign access = psel && penable;
  assign word_index = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
  assign hit_ctrl = aligned && (word_index == CTRL_INDEX);
  assign hit_sel = aligned && (word_index == SEL_INDEX);
  assign hit_status = aligned && (word_index == STATUS_INDEX);
  assign mapped = hit_ctrl || hit_sel || hit_status;

  // Writes land only at the edge that completes the access phase.
  assign wr_take = access && pready_q && pwrite && mapped;
  assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  always_comb begin
    status_word = 16'h0000;
    status_word[ST_BUSY_BIT] = adc_busy_q;
    status_word[ST_POWERED_BIT] = adc_power_on_q;
    status_word[ST_WAKING_BIT] = sq.waking;
    status_word[ST_SLOT_LSB +: 3] = conv_slot_q;
    status_word[ST_COUNT_LSB +: 8] = seq_count_q;
  end

  always_comb begin
    read_word = 16'h0000;
    if (hit_ctrl) begin
      read_word = ctrl_q & CTRL_WRITE_MASK;
    end else if (hit_sel) begin
      read_word = sel_q;
    end else if (hit_status) begin
      read_word = status_word;
    end
  end

  // One wait state: ready rises in the second access cycle, data ready with it.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= access && !pready_q;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (access && !pready_q) begin
      prdata_q <= pwrite ? 32'h0000_0000 : {16'h0000, read_word};
      pslverr_q <= !mapped || (pwrite && hit_status);
    end else if (!access) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Registers.
  // ****************************************************************
  // The sequencer reads the fields live; software must stop conversions before
  // rewriting them, so no shadow copy is kept.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_take && hit_ctrl) begin
      ctrl_q <= ((pwdata[15:0] & lane_mask) | (ctrl_q & ~lane_mask))
                & CTRL_WRITE_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_q <= SEL_RESET;
    end else if (wr_take && hit_sel) begin
      sel_q <= (pwdata[15:0] & lane_mask) | (sel_q & ~lane_mask);
    end
  end

  // A write that sets single or continuous mode is the start command.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      start_req_q <= 1'b0;
    end else begin
      start_req_q <= wr_take && hit_ctrl && pstrb[1] &&
                     (pwdata[SEQ_LSB +: 2] == SEQ_SINGLE ||
                      pwdata[SEQ_LSB +: 2] == SEQ_CONTINUOUS);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      seq_count_q <= 8'h00;
    end else if (sq.seq_end) begin
      seq_count_q <= 8'(seq_count_q + 8'h01);
    end
  end

  // ****************************************************************
  // Power-up timer.
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_cnt_q <= '0;
      wake_done_q <= 1'b0;
    end else if (sq.waking && !wake_done_q) begin
      wake_done_q <= (wake_cnt_q == WAKE_LAST);
      wake_cnt_q <= WAKE_W'(wake_cnt_q + 1'b1);
    end else begin
      wake_cnt_q <= '0;
      wake_done_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Sequencer.
  // ****************************************************************
  assign sq.seq_code = ctrl_q[SEQ_LSB +: 2];
  assign sq.start_req = start_req_q;
  assign sq.slot_en = {ctrl_q[DIAG_EN_LSB +: DIAG_SLOTS],
                       ctrl_q[MAIN_EN_LSB +: MAIN_SLOTS]};
  assign sq.wake_done = wake_done_q;
  assign sq.conv_done = conv_done;

  adcsq_sequencer u_seq (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .sq(sq.seq)
  );

  // ****************************************************************
  // Diagnostic rate and routing.
  // ****************************************************************
  logic [1:0] rate_dec;

  always_comb begin
    case (ctrl_q[RATE_LSB +: 2])
      RATE_4K8SPS: rate_dec = RATE_4K8SPS;
      RATE_9K6SPS: rate_dec = RATE_9K6SPS;
      default: rate_dec = RATE_20SPS;
    endcase
  end

  logic [4:0] node_dec [DIAG_SLOTS];

  // The low field has the full table; the others reuse it, with code 1111
  // turning into the sourcing measurement.
  for (genvar d = 0; d < DIAG_SLOTS; d++) begin : g_diag
    logic [3:0] code;
    assign code = sel_q[d*SEL_FIELD_W +: SEL_FIELD_W];
    always_comb begin
      case (code)
        4'h0: node_dec[d] = NODE_ANALOG_GROUND;
        4'h1: node_dec[d] = NODE_TEMPERATURE;
        4'h2: node_dec[d] = NODE_DIGITAL_SUPPLY;
        4'h3: node_dec[d] = NODE_ANALOG_SUPPLY;
        4'h4: node_dec[d] = NODE_ANALOG_REGULATOR_1V8;
        4'h5: node_dec[d] = NODE_DIGITAL_REGULATOR_1V8;
        4'h6: node_dec[d] = NODE_REFERENCE_OUTPUT;
        4'h7: node_dec[d] = NODE_POSITIVE_SUPPLY;
        4'h8: node_dec[d] = NODE_NEGATIVE_SUPPLY;
        4'h9: node_dec[d] = NODE_LOW_VOLTAGE_INPUT;
        4'ha: node_dec[d] = NODE_SENSE_LOW;
        4'hb: node_dec[d] = NODE_EXTERNAL_SENSE_ONE;
        4'hc: node_dec[d] = NODE_EXTERNAL_SENSE_TWO;
        4'hd: node_dec[d] = NODE_OUTPUT_SUPPLY;
        4'he: node_dec[d] = NODE_ANALOG_GROUND;
        default: begin
          node_dec[d] = (d == 0) ? NODE_SINK_CURRENT : NODE_SOURCE_CURRENT;
        end
      endcase
    end
  end

  logic slot_diag;
  logic [1:0] diag_idx;

  assign slot_diag = (sq.slot >= 3'(MAIN_SLOTS));
  assign diag_idx = 2'(sq.slot - 3'(MAIN_SLOTS));

  // ****************************************************************
  // Converter outputs.
  // ****************************************************************
  // Slot and route are registered in the same edge as the start pulse, so the
  // converter sees them aligned.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_start_q <= 1'b0;
    end else begin
      conv_start_q <= sq.conv_start;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_slot_q <= 3'h0;
    end else begin
      conv_slot_q <= sq.slot;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_is_diag_q <= 1'b0;
    end else begin
      conv_is_diag_q <= slot_diag;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      diag_rate_q <= RATE_20SPS;
    end else begin
      diag_rate_q <= rate_dec;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      diag_node_q <= NODE_ANALOG_GROUND;
    end else begin
      diag_node_q <= slot_diag ? node_dec[diag_idx] : NODE_ANALOG_GROUND;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      diag_code_q <= 4'h0;
    end else begin
      diag_code_q <= slot_diag ? sel_q[diag_idx*SEL_FIELD_W +: SEL_FIELD_W] : 4'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      adc_power_on_q <= 1'b1;
    end else begin
      adc_power_on_q <= sq.powered;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      adc_busy_q <= 1'b0;
    end else begin
      adc_busy_q <= sq.busy;
    end
  end

  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign conv_start = conv_start_q;
  assign conv_slot = conv_slot_q;
  assign conv_is_diag = conv_is_diag_q;
  assign diag_rate = diag_rate_q;
  assign diag_node = diag_node_q;
  assign diag_code = diag_code_q;
  assign adc_power_on = adc_power_on_q;
  assign adc_busy = adc_busy_q;

endmodule : adcsq_top

// >>> tb/adcsq_properties.sv
// Port-level assertions for the converter sequence control block.
module adcsq_properties
  import adcsq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic conv_start,
  input wire logic [2:0] conv_slot,
  input wire logic conv_is_diag,
  input wire logic [1:0] diag_rate,
  input wire logic [4:0] diag_node,
  input wire logic [3:0] diag_code,
  input wire logic adc_power_on,
  input wire logic adc_busy
);
  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_access: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready outside an access phase");
  a_rate_fallback: assert property (diag_rate != 2'h3)
    else $error("diagnostic rate code 3 driven");
  a_slot_kind: assert property (conv_start |-> conv_is_diag == (conv_slot >= 3'h2))
    else $error("slot kind flag wrong");
  a_node_direct: assert property (conv_start && conv_is_diag && diag_code < 4'he
    |-> diag_node == {1'h0, diag_code}) else $error("node does not follow code");
  a_ground_alias: assert property (conv_start && conv_is_diag && diag_code == 4'he
    |-> diag_node == NODE_ANALOG_GROUND) else $error("code 14 not ground");
  a_sink_current: assert property (conv_start && conv_slot == 3'h2 && diag_code == 4'hf
    |-> diag_node == NODE_SINK_CURRENT) else $error("slot 0 code 15 not sinking");
  a_source_current: assert property (conv_start && conv_slot > 3'h2 && diag_code == 4'hf
    |-> diag_node == NODE_SOURCE_CURRENT) else $error("upper code 15 not sourcing");
  a_busy_powered: assert property (conv_start |-> adc_busy && adc_power_on)
    else $error("conversion while idle or unpowered");
  a_reserved_zero: assert property (pready && !pwrite && paddr == 12'h0ec
    |-> prdata[7:2] == 6'h00) else $error("reserved control bits not zero");

  c_diag_conv: cover property (conv_start && conv_is_diag);
  c_power_down: cover property ($fell(adc_power_on));
  c_source: cover property (conv_start && diag_node == NODE_SOURCE_CURRENT);
endmodule : adcsq_properties

bind adcsq_top adcsq_properties u_adcsq_properties (
  .sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pready, .prdata, .conv_start,
  .conv_slot, .conv_is_diag, .diag_rate, .diag_node, .diag_code, .adc_power_on, .adc_busy
);

// >>> tb/adcsq_top_tb.sv
// Self-checking bench for the converter sequence control block.
module adcsq_top_tb
  import adcsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Signals and design.
  // ****************************************************************
  localparam int WAKE = 8;
  logic sys_clk = 1'h0;
  logic reset_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic conv_done = 1'h0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, adc_power_on, conv_start, conv_is_diag, adc_busy;
  logic [31:0] prdata;
  logic [2:0] conv_slot;
  logic [1:0] diag_rate;
  logic [4:0] diag_node;
  logic [3:0] diag_code;
  logic [32:0] rd_q[$];
  logic [14:0] cv_q[$];
  logic [15:0] sel_v, ctl_v;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;

  always #2 sys_clk = ~sys_clk;

  adcsq_top #(.WAKE_CYCLES(WAKE)) u_adcsq_top (
    .sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
    .prdata, .pslverr, .conv_done, .adc_power_on, .conv_start, .conv_slot,
    .conv_is_diag, .diag_rate, .diag_node, .diag_code, .adc_busy
  );

  // ****************************************************************
  // Checking and bus tasks.
  // ****************************************************************
  task automatic tally(string what, bit bad, logic [32:0] e, logic [32:0] g);
    compares++;
    if (bad) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : tally
  task automatic chk_rd(string what, logic [32:0] e, logic [32:0] g);
    tally(what, g !== e, e, g);
  endtask : chk_rd
  task automatic chk_cv(string what, logic [14:0] e, logic [14:0] g);
    tally(what, g !== e, 33'(e), 33'(g));
  endtask : chk_cv
  task automatic chk_fl(string what, logic e, logic g);
    tally(what, g !== e, 33'(e), 33'(g));
  endtask : chk_fl

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  // Entered just after a clock edge; psel is left high so that a following call
  // makes a back-to-back setup cycle without touching psel twice in one step.
  task automatic apb(logic w, logic [11:0] a, logic [15:0] d, logic [3:0] s, logic e,
                     logic [15:0] x);
    int n;
    rd_q.push_back({e, 16'h0000, w ? 16'h0000 : x});
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'($urandom), d};
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    penable <= 1'h0;
  endtask : apb

  function automatic logic [14:0] conv_exp(int s, logic [15:0] c);
    logic [3:0] k;
    logic [4:0] nd;
    k = (s < 2) ? 4'h0 : sel_v[4*(s-2) +: 4];
    nd = {1'h0, k};
    if (k == 4'he) nd = 5'(NODE_ANALOG_GROUND);
    if (k == 4'hf) nd = (s == 2) ? 5'(NODE_SINK_CURRENT) : 5'(NODE_SOURCE_CURRENT);
    return {3'(s), s >= 2, (c[15:14] == 2'h3) ? 2'h0 : c[15:14], nd, k};
  endfunction : conv_exp

  task automatic push_seq(logic [15:0] c, int reps);
    for (int r = 0; r < reps; r++) begin
      for (int s = 0; s < SLOTS; s++) begin
        if (c[s < 2 ? s : s + 6]) cv_q.push_back(conv_exp(s, c));
      end
    end
  endtask : push_seq

  task automatic wait_idle();
    int n;
    n = 0;
    psel <= 1'h0;
    repeat (8) @(posedge sys_clk);
    while (adc_busy !== 1'h0 && n < 1000) begin
      @(posedge sys_clk);
      n++;
    end
  endtask : wait_idle

  // ****************************************************************
  // Monitors, converter responder and watchdog.
  // ****************************************************************
  always @(posedge sys_clk) begin : mon_apb
    logic [32:0] e;
    if (psel && penable && pready === 1'h1) begin
      chk_fl("apb answer expected", 1'h1, rd_q.size() > 0);
      e = rd_q.pop_front();
      if (pwrite) chk_fl("pslverr", e[32], pslverr);
      else chk_rd("read answer", e, {pslverr, prdata});
    end
  end

  always @(posedge sys_clk) begin : mon_cv
    if (conv_start === 1'h1) begin
      chk_fl("conversion expected", 1'h1, cv_q.size() > 0);
      chk_cv("conversion", cv_q.pop_front(),
             {conv_slot, conv_is_diag, diag_rate, diag_node, diag_code});
    end
  end

  always @(posedge sys_clk) begin : responder
    if (conv_start === 1'h1) begin
      repeat ($urandom_range(13, 6)) @(posedge sys_clk);
      conv_done <= 1'h1;
      @(posedge sys_clk);
      conv_done <= 1'h0;
    end
  end

  always @(posedge sys_clk) begin : watchdog
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("timeout after %0d cycles", cyc);
      wrap_up();
    end
  end

  // ****************************************************************
  // Tests.
  // ****************************************************************
  initial begin
    int n;
    void'($urandom(36));
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'h1;
    @(posedge sys_clk);
    apb(1'h0, 12'h0ec, 16'h0000, 4'h3, 1'h0, CTRL_RESET);
    apb(1'h0, 12'h0f0, 16'h0000, 4'h3, 1'h0, SEL_RESET);
    apb(1'h0, 12'h0fc, 16'h0000, 4'h3, 1'h0, 16'h0002);
    apb(1'h1, 12'h0ec, 16'hc0fc, 4'h3, 1'h0, 16'h0000);
    apb(1'h0, 12'h0ec, 16'h0000, 4'h3, 1'h0, 16'hc000);
    sel_v = 16'($urandom);
    apb(1'h1, 12'h0f0, sel_v, 4'h3, 1'h0, 16'h0000);
    apb(1'h1, 12'h0f0, 16'h5a5a, 4'h1, 1'h0, 16'h0000);
    sel_v[7:0] = 8'h5a;
    apb(1'h1, 12'h100, 16'hffff, 4'h3, 1'h1, 16'h0000);
    apb(1'h0, 12'h0ee, 16'h0000, 4'h3, 1'h1, 16'h0000);
    apb(1'h1, 12'h0fc, 16'hffff, 4'h3, 1'h1, 16'h0000);
    apb(1'h0, 12'h0f0, 16'h0000, 4'h3, 1'h0, sel_v);
    psel <= 1'h0;
    $display("test registers finished");
    // Every slot 0 code and every rate code, with random enables and upper fields.
    for (int i = 0; i < 16; i++) begin
      apb(1'h1, 12'h0ec, 16'h0000, 4'h3, 1'h0, 16'h0000);
      sel_v = {12'($urandom), 4'(i)};
      ctl_v = {2'(i), 2'h1, 3'($urandom), 1'h1, 6'h00, 2'($urandom)};
      apb(1'h1, 12'h0f0, sel_v, 4'h3, 1'h0, 16'h0000);
      push_seq(ctl_v, 1);
      apb(1'h1, 12'h0ec, ctl_v, 4'h3, 1'h0, 16'h0000);
      wait_idle();
      chk_fl("single sequence drained", 1'h1, cv_q.size() == 0);
      chk_fl("idle stays powered", 1'h1, adc_power_on);
    end
    $display("test single sequences finished");
    apb(1'h1, 12'h0ec, 16'h0000, 4'h3, 1'h0, 16'h0000);
    ctl_v = 16'h2101;
    push_seq(ctl_v, 2);
    apb(1'h1, 12'h0ec, ctl_v, 4'h3, 1'h0, 16'h0000);
    psel <= 1'h0;
    n = 0;
    while (cv_q.size() > 1 && n < 500) begin
      @(posedge sys_clk);
      n++;
    end
    chk_fl("busy while looping", 1'h1, adc_busy);
    apb(1'h1, 12'h0ec, 16'h0101, 4'h3, 1'h0, 16'h0000);
    wait_idle();
    chk_fl("loop ends at sequence end", 1'h1, cv_q.size() == 0);
    chk_fl("standby stays powered", 1'h1, adc_power_on);
    $display("test continuous finished");
    apb(1'h1, 12'h0ec, 16'h3000, 4'h3, 1'h0, 16'h0000);
    psel <= 1'h0;
    repeat (4) @(posedge sys_clk);
    chk_fl("powered down", 1'h0, adc_power_on);
    ctl_v = 16'h5001;
    push_seq(ctl_v, 1);
    apb(1'h1, 12'h0ec, ctl_v, 4'h3, 1'h0, 16'h0000);
    psel <= 1'h0;
    n = 0;
    while (conv_start !== 1'h1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    chk_fl("wake delay kept", 1'h1, n > WAKE);
    wait_idle();
    chk_fl("woken sequence drained", 1'h1, cv_q.size() == 0);
    apb(1'h1, 12'h0ec, 16'h3000, 4'h3, 1'h0, 16'h0000);
    apb(1'h1, 12'h0ec, 16'h0000, 4'h3, 1'h0, 16'h0000);
    psel <= 1'h0;
    repeat (WAKE + 8) @(posedge sys_clk);
    chk_fl("standby wakes converter", 1'h1, adc_power_on);
    $display("test power down finished");
    wrap_up();
  end
endmodule : adcsq_top_tb
